/* src/tsq_regs.svh */
// Purpose: Register indices, field positions and reset values of the sensor register bank
// Assumes: Byte address on the bus is four times the register index
// Notes: Definitions only
`ifndef TSQ_REGS_SVH
`define TSQ_REGS_SVH
`define TSQ_IDX_W 8
`define TSQ_IDX_STATUS 8'h00
`define TSQ_IDX_IEN 8'h01
`define TSQ_IDX_WR_IDX 8'h04
`define TSQ_IDX_RD_IDX 8'h05
`define TSQ_IDX_LOST 8'h06
`define TSQ_IDX_FILL 8'h07
`define TSQ_IDX_DATA 8'h08
`define TSQ_IDX_THR 8'h09
`define TSQ_IDX_CTRL 8'h0A
`define TSQ_IDX_IRQ_CLR 8'h0C
`define TSQ_IDX_HI_UPPER 8'h10
`define TSQ_IDX_HI_LOWER 8'h11
`define TSQ_BIT_AFULL 7
`define TSQ_BIT_LOW 2
`define TSQ_BIT_HIGH 1
`define TSQ_BIT_DONE 0
`define TSQ_BIT_FLUSH 4
`define TSQ_BIT_CLR_POP 3
`define TSQ_BIT_AF_STYLE 2
`define TSQ_BIT_ROLL 1
`define TSQ_IRQ_MASK 8'h87
`define TSQ_CTRL_MASK 8'h1E
`define TSQ_RST_IEN 8'h00
`define TSQ_RST_STATUS 8'h00
`define TSQ_RST_RD_IDX 5'h00
`define TSQ_RST_THR 5'h0F
`define TSQ_RST_CTRL 8'h00
`define TSQ_RST_HI_UPPER 8'h7F
`define TSQ_RST_HI_LOWER 8'hFF
`endif

/* src/tsq_pkg.sv */
// Purpose: Types shared by the sensor register bank
// Assumes: Nothing beyond the register header
// Notes: All state of the bank is one struct
`default_nettype none
package tsq_pkg;
	typedef struct packed {
		logic [4:0] wr_idx;
		logic [5:0] fill;
		logic [4:0] lost;
		logic [7:0] data;
	} tsq_queue_t;
	typedef struct packed {
		logic [4:0] rd_idx;
		logic [4:0] af_thr;
		logic flush;
		logic clr_on_pop;
		logic af_style;
		logic rollover;
		logic [15:0] hi_thr;
	} tsq_cfg_t;
	typedef struct packed {
		logic ack;
		logic [7:0] ien;
		logic [7:0] status;
		logic [4:0] rd_idx;
		logic [4:0] af_thr;
		logic [7:0] ctrl;
		logic [7:0] hi_upper;
		logic [7:0] hi_lower;
		logic [31:0] rdata;
	} tsq_state_t;
endpackage
`default_nettype wire

/* src/tsq_regs_top.sv */
// Purpose: Avalon-MM register bank with status flags, enables and interrupt of a temp sensor
// Assumes: Queue and conversion logic sit outside and feed the inputs here
// Notes: Every access takes one wait cycle; read side effects act at completion
//
// Added by the designer: the Avalon-MM interface to the registers.
`include "tsq_regs.svh"
`default_nettype none

module tsq_regs_top (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Avalon-MM slave
	input wire logic [9:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Measurement and queue events
	input wire logic temp_valid_i,
	input wire logic [15:0] temp_value_i,
	input wire logic below_low_i,
	input wire logic almost_full_i,
	input wire tsq_pkg::tsq_queue_t queue_i,
	input wire logic pin_irq_sel_i,
	// Queue control and interrupt
	output tsq_pkg::tsq_cfg_t cfg_o,
	output logic queue_pop_o,
	output logic irq_o
);
	tsq_pkg::tsq_state_t st_q;
	tsq_pkg::tsq_state_t st_d;
	logic [7:0] idx;
	logic busy;
	logic rd_fire;
	logic wr_fire;
	logic wr_lane;
	logic pop;
	logic above_high;
	logic [7:0] set_ev;
	logic [7:0] clr_ev;

	function automatic logic [31:0] read_mux(input logic [7:0] i,
			input tsq_pkg::tsq_state_t s, input tsq_pkg::tsq_queue_t q);
		logic [31:0] r;
		r = 32'h0000_0000;
		unique case (i)
			`TSQ_IDX_STATUS: r[7:0] = s.status;
			`TSQ_IDX_IEN: r[7:0] = s.ien;
			`TSQ_IDX_WR_IDX: r[4:0] = q.wr_idx;
			`TSQ_IDX_RD_IDX: r[4:0] = s.rd_idx;
			`TSQ_IDX_LOST: r[4:0] = q.lost;
			`TSQ_IDX_FILL: r[5:0] = q.fill;
			`TSQ_IDX_DATA: r[7:0] = q.data;
			`TSQ_IDX_THR: r[4:0] = s.af_thr;
			`TSQ_IDX_CTRL: r[7:0] = s.ctrl;
			`TSQ_IDX_HI_UPPER: r[7:0] = s.hi_upper;
			`TSQ_IDX_HI_LOWER: r[7:0] = s.hi_lower;
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	assign idx = avs_address_i[9:2];
	assign busy = avs_read_i | avs_write_i;
	assign rd_fire = avs_read_i & st_q.ack;
	assign wr_fire = avs_write_i & st_q.ack;
	assign wr_lane = wr_fire & avs_byteenable_i[0];
	assign pop = rd_fire && (idx == `TSQ_IDX_DATA);
	assign above_high = $signed(temp_value_i) > $signed({st_q.hi_upper, st_q.hi_lower});

	always_comb begin
		set_ev = 8'h00;
		set_ev[`TSQ_BIT_AFULL] = almost_full_i;
		set_ev[`TSQ_BIT_LOW] = below_low_i;
		set_ev[`TSQ_BIT_HIGH] = temp_valid_i & above_high;
		set_ev[`TSQ_BIT_DONE] = temp_valid_i;
	end

	always_comb begin
		clr_ev = 8'h00;
		// Only clear what the completing read actually returned
		if (rd_fire && (idx == `TSQ_IDX_STATUS)) begin
			clr_ev = st_q.rdata[7:0];
		end
		if (wr_lane && (idx == `TSQ_IDX_IRQ_CLR)) begin
			clr_ev = clr_ev | avs_writedata_i[7:0];
		end
		if (pop) begin
			clr_ev[`TSQ_BIT_DONE] = 1'b1;
			if (st_q.ctrl[`TSQ_BIT_CLR_POP]) begin
				clr_ev[`TSQ_BIT_AFULL] = 1'b1;
			end
		end
	end

	always_comb begin
		st_d = st_q;
		st_d.ack = busy & ~st_q.ack;
		if (busy & ~st_q.ack) begin
			st_d.rdata = avs_read_i ? read_mux(idx, st_q, queue_i) : 32'h0000_0000;
		end
		// Set wins over clear
		st_d.status = ((st_q.status & ~clr_ev) | set_ev) & `TSQ_IRQ_MASK;
		if (pop && (queue_i.fill != 6'h00)) begin
			st_d.rd_idx = st_q.rd_idx + 5'h01;
		end
		if (wr_lane) begin
			unique case (idx)
				`TSQ_IDX_IEN: st_d.ien = avs_writedata_i[7:0] & `TSQ_IRQ_MASK;
				`TSQ_IDX_RD_IDX: st_d.rd_idx = avs_writedata_i[4:0];
				`TSQ_IDX_THR: st_d.af_thr = avs_writedata_i[4:0];
				`TSQ_IDX_CTRL: st_d.ctrl = avs_writedata_i[7:0] & `TSQ_CTRL_MASK;
				`TSQ_IDX_HI_UPPER: st_d.hi_upper = avs_writedata_i[7:0];
				`TSQ_IDX_HI_LOWER: st_d.hi_lower = avs_writedata_i[7:0];
				default: st_d.ack = st_d.ack;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q.ack <= 1'b0;
			st_q.ien <= `TSQ_RST_IEN;
			st_q.status <= `TSQ_RST_STATUS;
			st_q.rd_idx <= `TSQ_RST_RD_IDX;
			st_q.af_thr <= `TSQ_RST_THR;
			st_q.ctrl <= `TSQ_RST_CTRL;
			st_q.hi_upper <= `TSQ_RST_HI_UPPER;
			st_q.hi_lower <= `TSQ_RST_HI_LOWER;
			st_q.rdata <= 32'h0000_0000;
		end else begin
			st_q <= st_d;
		end
	end

	assign avs_waitrequest_o = busy & ~st_q.ack;
	assign avs_readdata_o = st_q.rdata;
	assign queue_pop_o = pop;
	assign irq_o = pin_irq_sel_i & (|(st_q.status & st_q.ien));

	always_comb begin
		cfg_o.rd_idx = st_q.rd_idx;
		cfg_o.af_thr = st_q.af_thr;
		cfg_o.flush = st_q.ctrl[`TSQ_BIT_FLUSH];
		cfg_o.clr_on_pop = st_q.ctrl[`TSQ_BIT_CLR_POP];
		cfg_o.af_style = st_q.ctrl[`TSQ_BIT_AF_STYLE];
		cfg_o.rollover = st_q.ctrl[`TSQ_BIT_ROLL];
		cfg_o.hi_thr = {st_q.hi_upper, st_q.hi_lower};
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_afull_irq_gate: assert property (
		st_q.status[`TSQ_BIT_AFULL] && pin_irq_sel_i |-> irq_o == st_q.ien[`TSQ_BIT_AFULL]
			|| |(st_q.status[2:0] & st_q.ien[2:0]))
		else $error("almost full gating wrong");
	a_low_irq_gate: assert property (
		st_q.ien[`TSQ_BIT_LOW] && st_q.status[`TSQ_BIT_LOW] && pin_irq_sel_i |-> irq_o)
		else $error("below low flag not on interrupt");
	a_high_irq_gate: assert property (
		st_q.ien[`TSQ_BIT_HIGH] && st_q.status[`TSQ_BIT_HIGH] && pin_irq_sel_i |-> irq_o)
		else $error("above high flag not on interrupt");
	a_done_irq_mask: assert property (
		!st_q.ien[`TSQ_BIT_DONE] && (st_q.status & st_q.ien) == 8'h00 |-> !irq_o)
		else $error("masked conversion done raised interrupt");
	a_wr_idx_read: assert property (
		avs_read_i && !avs_waitrequest_o && idx == `TSQ_IDX_WR_IDX
			|-> avs_readdata_o == {27'h000_0000, $past(queue_i.wr_idx)})
		else $error("write index readback wrong");
	a_rd_idx_load: assert property (
		wr_lane && idx == `TSQ_IDX_RD_IDX |=> st_q.rd_idx == $past(avs_writedata_i[4:0]))
		else $error("read index not loaded");
	a_thr_reset: assert property (
		$fell(rst_i) |-> st_q.af_thr == `TSQ_RST_THR && st_q.ctrl == `TSQ_RST_CTRL)
		else $error("threshold reset value wrong");
	a_hi_default: assert property (
		$fell(rst_i) |-> cfg_o.hi_thr == 16'h7FFF)
		else $error("high threshold default wrong");
	a_high_set: assert property (
		temp_valid_i && above_high |=> st_q.status[`TSQ_BIT_HIGH] [*1] ##1 1'b1)
		else $error("above high flag not set");
	a_afull_pop_clr: assert property (
		pop && st_q.ctrl[`TSQ_BIT_CLR_POP] && !almost_full_i |=> !st_q.status[`TSQ_BIT_AFULL])
		else $error("almost full not cleared on pop");
	a_irq_release: assert property (
		(st_q.status & st_q.ien) == 8'h00 |-> !irq_o)
		else $error("interrupt held without enabled flag");
	a_wait_one: assert property (
		busy && avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("access took more than one wait cycle");

	a_afull_mask: assert property (
		!st_q.ien[`TSQ_BIT_AFULL] && (st_q.status[2:0] & st_q.ien[2:0]) == 3'h0
			|-> !irq_o)
		else $error("masked almost full raised interrupt");

	a_afull_irq_set: assert property (
		st_q.ien[`TSQ_BIT_AFULL] && st_q.status[`TSQ_BIT_AFULL] && pin_irq_sel_i
			|-> irq_o)
		else $error("almost full flag not on interrupt");

	a_low_mask: assert property (
		st_q.ien == 8'h04 && !st_q.status[`TSQ_BIT_LOW]
			|-> !irq_o)
		else $error("interrupt without below low flag");

	a_high_mask: assert property (
		st_q.ien == 8'h02 && !st_q.status[`TSQ_BIT_HIGH]
			|-> !irq_o)
		else $error("interrupt without above high flag");

	a_done_irq_gate: assert property (
		st_q.ien[`TSQ_BIT_DONE] && st_q.status[`TSQ_BIT_DONE] && pin_irq_sel_i
			|-> irq_o)
		else $error("conversion done flag not on interrupt");

	a_pin_sel_gate: assert property (
		!pin_irq_sel_i
			|-> !irq_o)
		else $error("interrupt raised while pin not selected");

	a_irq_assert: assert property (
		pin_irq_sel_i && (st_q.status & st_q.ien) != 8'h00
			|-> irq_o)
		else $error("enabled flag did not raise interrupt");

	a_ien_write: assert property (
		wr_lane && idx == `TSQ_IDX_IEN
			|=> st_q.ien == ($past(avs_writedata_i[7:0]) & `TSQ_IRQ_MASK))
		else $error("enable register write wrong");

	a_ien_read: assert property (
		avs_read_i && !avs_waitrequest_o && idx == `TSQ_IDX_IEN
			|-> avs_readdata_o == {24'h00_0000, $past(st_q.ien)})
		else $error("enable register readback wrong");

	a_wr_idx_upper: assert property (
		avs_read_i && !avs_waitrequest_o && idx == `TSQ_IDX_WR_IDX
			|-> avs_readdata_o[31:5] == 27'h000_0000)
		else $error("write index upper bits not zero");

	a_rd_idx_read: assert property (
		avs_read_i && !avs_waitrequest_o && idx == `TSQ_IDX_RD_IDX
			|-> avs_readdata_o == {27'h000_0000, $past(st_q.rd_idx)})
		else $error("read index readback wrong");

	a_rd_idx_pop: assert property (
		pop && queue_i.fill != 6'h00
			|=> st_q.rd_idx == $past(st_q.rd_idx) + 5'h01)
		else $error("read index not advanced on pop");

	a_rd_idx_hold: assert property (
		!pop && !wr_lane
			|=> $stable(st_q.rd_idx))
		else $error("read index changed without cause");

	a_lost_read: assert property (
		avs_read_i && !avs_waitrequest_o && idx == `TSQ_IDX_LOST
			|-> avs_readdata_o == {27'h000_0000, $past(queue_i.lost)})
		else $error("lost sample count readback wrong");

	a_fill_read: assert property (
		avs_read_i && !avs_waitrequest_o && idx == `TSQ_IDX_FILL
			|-> avs_readdata_o == {26'h000_0000, $past(queue_i.fill)})
		else $error("fill level readback wrong");

	a_thr_write: assert property (
		wr_lane && idx == `TSQ_IDX_THR
			|=> st_q.af_thr == $past(avs_writedata_i[4:0]))
		else $error("threshold write wrong");

	a_thr_read: assert property (
		avs_read_i && !avs_waitrequest_o && idx == `TSQ_IDX_THR
			|-> avs_readdata_o == {27'h000_0000, $past(st_q.af_thr)})
		else $error("threshold readback wrong");

	a_ctrl_reserved: assert property (
		st_q.ctrl != 8'h00
			|-> (st_q.ctrl & ~`TSQ_CTRL_MASK) == 8'h00)
		else $error("reserved control bit set");

	a_ctrl_write: assert property (
		wr_lane && idx == `TSQ_IDX_CTRL
			|=> cfg_o.flush == $past(avs_writedata_i[`TSQ_BIT_FLUSH]))
		else $error("flush control write wrong");

	a_ctrl_roll: assert property (
		wr_lane && idx == `TSQ_IDX_CTRL
			|=> cfg_o.rollover == $past(avs_writedata_i[`TSQ_BIT_ROLL]))
		else $error("rollover control write wrong");

	a_ctrl_style: assert property (
		wr_lane && idx == `TSQ_IDX_CTRL
			|=> cfg_o.af_style == $past(avs_writedata_i[`TSQ_BIT_AF_STYLE]))
		else $error("assert style control write wrong");

	a_ctrl_pop_clr: assert property (
		wr_lane && idx == `TSQ_IDX_CTRL
			|=> cfg_o.clr_on_pop == $past(avs_writedata_i[`TSQ_BIT_CLR_POP]))
		else $error("clear on pop control write wrong");

	a_upper_write: assert property (
		wr_lane && idx == `TSQ_IDX_HI_UPPER
			|=> cfg_o.hi_thr[15:8] == $past(avs_writedata_i[7:0]))
		else $error("threshold upper byte write wrong");

	a_upper_reset: assert property (
		$fell(rst_i)
			|-> st_q.hi_upper == `TSQ_RST_HI_UPPER)
		else $error("threshold upper byte reset wrong");

	a_high_quiet: assert property (
		{st_q.hi_upper, st_q.hi_lower} == 16'h7FFF
			|-> !above_high)
		else $error("high alarm fired at top threshold");

	a_high_clear: assert property (
		rd_fire && idx == `TSQ_IDX_STATUS && st_q.rdata[`TSQ_BIT_HIGH] && !temp_valid_i
			|=> !st_q.status[`TSQ_BIT_HIGH])
		else $error("above high flag not cleared by read");

	a_afull_read_clr: assert property (
		rd_fire && idx == `TSQ_IDX_STATUS && st_q.rdata[`TSQ_BIT_AFULL] && !almost_full_i
			|=> !st_q.status[`TSQ_BIT_AFULL])
		else $error("almost full not cleared by read");

	a_lower_write: assert property (
		wr_lane && idx == `TSQ_IDX_HI_LOWER
			|=> cfg_o.hi_thr[7:0] == $past(avs_writedata_i[7:0]))
		else $error("threshold lower byte write wrong");

	a_lower_reset: assert property (
		$fell(rst_i)
			|-> st_q.hi_lower == `TSQ_RST_HI_LOWER)
		else $error("threshold lower byte reset wrong");

	a_irq_reset: assert property (
		$fell(rst_i)
			|-> !irq_o && st_q.ien == `TSQ_RST_IEN)
		else $error("interrupt or enables not reset");

	a_unmapped_read: assert property (
		avs_read_i && !avs_waitrequest_o && idx == `TSQ_IDX_IRQ_CLR
			|-> avs_readdata_o == 32'h0000_0000)
		else $error("write only clear register read nonzero");

	a_pop_pulse: assert property (
		pop
			|-> avs_read_i && !avs_waitrequest_o)
		else $error("pop outside a completing read");

	c_irq_rise: cover property ($rose(irq_o));
	c_status_read: cover property (rd_fire && idx == `TSQ_IDX_STATUS && st_q.rdata[1]);
	c_pop_clear: cover property (pop && st_q.ctrl[`TSQ_BIT_CLR_POP] && st_q.status[7]);
	c_high_alarm: cover property (temp_valid_i && above_high);
endmodule
`default_nettype wire

/* tb/tsq_queue_model.sv */
// Purpose: Queue side model feeding indices, counts and data
// Assumes: One pop per completed data read
// Notes: Data steps and fill drops on every pop while fill is nonzero
`default_nettype none
module tsq_queue_model (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Pop from the bank
	input wire logic pop_i,
	// Queue state
	output var tsq_pkg::tsq_queue_t q_o
);
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q_o <= '{wr_idx: 5'h03, fill: 6'h03, lost: 5'h01, data: 8'hA0};
		end else if (pop_i && q_o.fill != 6'h00) begin
			q_o.fill <= q_o.fill - 6'h01;
			q_o.data <= q_o.data + 8'h01;
		end
	end
endmodule
`default_nettype wire

/* tb/tb_tsq_regs_top.sv */
// Purpose: Self-checking bench of the sensor register bank
// Assumes: Byte address is four times the register index
// Notes: Queue side comes from the queue model
`default_nettype none
module tb_tsq_regs_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [9:0] adr = 10'h000;
	logic rd_r = 1'b0;
	logic wr_r = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic wq;
	logic tv = 1'b0;
	logic [15:0] tval = 16'h0000;
	logic lo = 1'b0;
	logic af = 1'b0;
	logic sel = 1'b1;
	logic pop;
	logic irq;
	logic [7:0] d;
	tsq_pkg::tsq_queue_t q;
	tsq_pkg::tsq_cfg_t cfg;
	logic [15:0] rtab [11] = '{16'h0100, 16'h0403, 16'h0500, 16'h0601, 16'h0703,
		16'h090F, 16'h0A00, 16'h107F, 16'h11FF, 16'h0000, 16'h3F00};
	logic [23:0] wtab [8] = '{24'h01FF87, 24'h09FF1F, 24'h0AFF1E, 24'h04FF03,
		24'h101010, 24'h110000, 24'h3FFF00, 24'h010000};
	logic [15:0] itab [4] = '{16'h8080, 16'h0404, 16'h0203, 16'h0101};
	int err_count = 0;
	int samples_checked = 0;
	int pops = 0;
	always #4 clk_i = ~clk_i;
	tsq_regs_top uut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(adr),
		.avs_read_i(rd_r), .avs_write_i(wr_r), .avs_byteenable_i(4'h1),
		.avs_writedata_i(wdat), .avs_readdata_o(rdat), .avs_waitrequest_o(wq),
		.temp_valid_i(tv), .temp_value_i(tval), .below_low_i(lo), .almost_full_i(af),
		.queue_i(q), .pin_irq_sel_i(sel), .cfg_o(cfg), .queue_pop_o(pop), .irq_o(irq));
	tsq_queue_model model (.clk_i(clk_i), .rst_i(rst_i), .pop_i(pop), .q_o(q));
	always @(posedge clk_i) if (pop === 1'b1) pops <= pops + 1;
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic acc(input logic [7:0] i, input logic w, input logic [7:0] v);
		adr <= {i, 2'b00};
		rd_r <= !w;
		wr_r <= w;
		wdat <= {24'h0, v};
		@(posedge clk_i);
		while (wq !== 1'b0) begin
			@(posedge clk_i);
		end
		d = rdat[7:0];
		rd_r <= 1'b0;
		wr_r <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic ev(input logic [7:0] s);
		af <= s[7];
		lo <= s[2];
		tv <= |s[1:0];
		tval <= s[1] ? 16'h1001 : 16'h1000;
		@(posedge clk_i);
		af <= 1'b0;
		lo <= 1'b0;
		tv <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic results();
		$display("checks %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		chk(cfg.hi_thr, 16'h7FFF);
		for (int k = 0; k < 11; k++) begin
			acc(rtab[k][15:8], 1'b0, 8'h00);
			chk({8'h00, d}, {8'h00, rtab[k][7:0]});
		end
		for (int k = 0; k < 8; k++) begin
			acc(wtab[k][23:16], 1'b1, wtab[k][15:8]);
			acc(wtab[k][23:16], 1'b0, 8'h00);
			chk({8'h00, d}, {8'h00, wtab[k][7:0]});
		end
		chk(cfg.hi_thr, 16'h1000);
		chk({7'h00, cfg.af_thr, cfg.flush, cfg.clr_on_pop, cfg.af_style, cfg.rollover}, 16'h01FF);
		for (int k = 0; k < 4; k++) begin
			ev(itab[k][15:8]);
			chk({15'h0, irq}, 16'h0000);
			acc(8'h01, 1'b1, itab[k][15:8]);
			chk({15'h0, irq}, 16'h0001);
			sel <= 1'b0;
			@(posedge clk_i);
			chk({15'h0, irq}, 16'h0000);
			sel <= 1'b1;
			acc(8'h00, 1'b0, 8'h00);
			chk({8'h00, d}, {8'h00, itab[k][7:0]});
			chk({15'h0, irq}, 16'h0000);
			acc(8'h01, 1'b1, 8'h00);
		end
		ev(8'h80);
		acc(8'h08, 1'b0, 8'h00);
		chk({8'h00, d}, 16'h00A0);
		acc(8'h00, 1'b0, 8'h00);
		chk({8'h00, d}, 16'h0000);
		acc(8'h05, 1'b0, 8'h00);
		chk({8'h00, d}, 16'h0001);
		acc(8'h0A, 1'b1, 8'h00);
		ev(8'h80);
		acc(8'h08, 1'b0, 8'h00);
		acc(8'h00, 1'b0, 8'h00);
		chk({8'h00, d}, 16'h0080);
		acc(8'h05, 1'b1, 8'h1F);
		acc(8'h05, 1'b0, 8'h00);
		chk({8'h00, d}, 16'h001F);
		chk({11'h000, cfg.rd_idx}, 16'h001F);
		chk(pops[15:0], 16'h0002);
		results();
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		err_count++;
		results();
	end
endmodule
`default_nettype wire
